/* File: pkg/panel_pkg.sv */
// Package of constants and types for the two-key panel mode control
// Behaviour
// RULE1 - Short press: next page or value plus one
// RULE2 - Long press: previous page or value minus one
// RULE3 - Both keys held one second toggle mode
// RULE4 - Power-up always starts in display mode
// RULE5 - Display mode: key one selects phase
// RULE6 - Display mode: key two steps measured quantity
// RULE7 - Programming entry asks password when one configured
// RULE8 - Programming shows indicator text, blinks address digits
// RULE9 - Sixty seconds without keys returns to display
// RULE10 - Password is four decimal digits
// RULE11 - Password held at address 500, zero disables
// RULE12 - Delivered with no password set
// RULE13 - Hold time threshold splits short/long, once per press
package panel_pkg;
  // Clock rate in Hz
  localparam int unsigned CLK_HZ = 50000000;
  // Timing figures in milliseconds
  localparam int unsigned LONG_PRESS_MS = 800;
  localparam int unsigned BOTH_HOLD_MS = 1000;
  localparam int unsigned IDLE_TIMEOUT_MS = 60000;
  localparam int unsigned BLINK_HALF_MS = 250;
  // Derived cycle counts (least times round up)
  localparam longint unsigned LONG_PRESS_CYC = (longint'(LONG_PRESS_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned BOTH_HOLD_CYC = (longint'(BOTH_HOLD_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned IDLE_TIMEOUT_CYC = (longint'(IDLE_TIMEOUT_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned BLINK_HALF_CYC = (longint'(BLINK_HALF_MS) * CLK_HZ + 999) / 1000;
  // Parameter address of the display password
  localparam logic [9:0] PASSWORD_ADDR = 10'h1f4;
  // Highest parameter address, stepping wraps past it
  localparam logic [9:0] ADDR_LAST = 10'h3e7;
  // Factory password value: none set
  localparam logic [15:0] PASSWORD_RESET = 16'h0000;
  // Reset values of page selectors
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam logic [3:0] QUANTITY_RESET = 4'h0;
  localparam logic [9:0] ADDR_RESET = 10'h000;
  // Panel operating modes
  typedef enum logic [1:0] {MODE_DISPLAY, MODE_PASSWORD, MODE_PROGRAM} panel_mode_t;
  // Decoded key events of one key
  typedef struct packed {
    logic short_press;
    logic long_press;
  } key_event_t;
  // Display driving bundle
  typedef struct packed {
    logic programming_indicator_text;
    logic password_query;
    logic addr_blank;
    logic digit_blank;
    logic [1:0] phase;
    logic [3:0] quantity;
    logic [9:0] addr;
    logic [1:0] digit_sel;
    logic [15:0] value;
  } display_t;
endpackage

/* File: verilog/two_key_panel_mode_control.sv */
`timescale 1ns/1ps
// Two-key front panel: press decoding, display/programming modes, password, timeout
module two_key_panel_mode_control #(
  parameter longint unsigned LONG_CYC = panel_pkg::LONG_PRESS_CYC,
  parameter longint unsigned BOTH_CYC = panel_pkg::BOTH_HOLD_CYC,
  parameter longint unsigned IDLE_CYC = panel_pkg::IDLE_TIMEOUT_CYC,
  parameter longint unsigned BLINK_CYC = panel_pkg::BLINK_HALF_CYC,
  parameter int unsigned NUM_PHASES = 4,
  parameter int unsigned NUM_QUANTITIES = 12
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_key1,
  input wire logic i_key2,
  input wire logic [15:0] i_param_value,
  output panel_pkg::display_t o_display,
  output logic [9:0] o_param_addr,
  output logic [15:0] o_param_wdata,
  output logic o_param_we
);
  import panel_pkg::*;

  // Reset release through two flops
  logic rst_sync1_reg;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n <= rst_sync1_reg;
    end
  end

  // Key synchronisers, three stages each
  logic [2:0] k1_sync_reg;
  logic [2:0] k2_sync_reg;
  logic k1_reg;
  logic k2_reg;
  logic k1_next;
  logic k2_next;
  always_comb begin
    // Level changes only when stages two and three agree
    k1_next = (k1_sync_reg[1] == k1_sync_reg[2]) ? k1_sync_reg[2] : k1_reg;
    k2_next = (k2_sync_reg[1] == k2_sync_reg[2]) ? k2_sync_reg[2] : k2_reg;
  end
  // Shift key pins through the synchroniser and hold the accepted level
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      k1_sync_reg <= 3'h0;
      k2_sync_reg <= 3'h0;
      k1_reg <= 1'b0;
      k2_reg <= 1'b0;
    end else begin
      k1_sync_reg <= {k1_sync_reg[1:0], i_key1};
      k2_sync_reg <= {k2_sync_reg[1:0], i_key2};
      k1_reg <= k1_next;
      k2_reg <= k2_next;
    end
  end

  // Saturating hold counter step
  function automatic logic [31:0] count_up(input logic [31:0] c);
    count_up = (c == 32'hffffffff) ? c : c + 32'h1;
  endfunction

  // Press decoding: hold timers, chord detection, lockout until all released
  logic [31:0] h1_reg; // Cycles key one has been held
  logic [31:0] h1_next; // Next hold count of key one
  logic [31:0] h2_reg; // Cycles key two has been held
  logic [31:0] h2_next; // Next hold count of key two
  logic [31:0] both_reg; // Cycles both keys have been held together
  logic [31:0] both_next; // Next chord count
  logic lock_reg; // Chord seen, single-key actions blocked
  logic lock_next; // Next lockout state
  key_event_t ev1; // Press decoded on key one this cycle
  key_event_t ev2; // Press decoded on key two this cycle
  logic toggle; // Chord reached its hold time this cycle
  always_comb begin
    h1_next = k1_reg ? count_up(h1_reg) : 32'h0;
    h2_next = k2_reg ? count_up(h2_reg) : 32'h0;
    both_next = (k1_reg && k2_reg) ? count_up(both_reg) : 32'h0;
    lock_next = lock_reg;
    ev1 = '0;
    ev2 = '0;
    toggle = 1'b0;
    if (k1_reg && k2_reg) begin
      // Chord suppresses single-key actions until both keys are up
      lock_next = 1'b1;
      toggle = (both_reg == 32'(BOTH_CYC - 1)); // see RULE3
    end else if (lock_reg) begin
      if (!k1_reg && !k2_reg) begin
        lock_next = 1'b0;
      end
    end else begin
      // Act once, on release, classified by hold time; see RULE13
      ev1.short_press = !k1_reg && h1_reg != 32'h0 && h1_reg < 32'(LONG_CYC); // see RULE1
      ev1.long_press = !k1_reg && h1_reg >= 32'(LONG_CYC); // see RULE2
      ev2.short_press = !k2_reg && h2_reg != 32'h0 && h2_reg < 32'(LONG_CYC);
      ev2.long_press = !k2_reg && h2_reg >= 32'(LONG_CYC);
    end
  end
  // Register hold timers and the chord lockout
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      h1_reg <= 32'h0;
      h2_reg <= 32'h0;
      both_reg <= 32'h0;
      lock_reg <= 1'b0;
    end else begin
      h1_reg <= h1_next;
      h2_reg <= h2_next;
      both_reg <= both_next;
      lock_reg <= lock_next;
    end
  end

  // Any key activity restarts the idle timer
  logic any_key;
  assign any_key = k1_reg | k2_reg;

  // Mode, selectors, editing and timers
  panel_mode_t mode_reg; // Current panel mode
  panel_mode_t mode_next; // Mode for the next cycle
  logic [1:0] phase_reg; // Phase shown in display mode
  logic [1:0] phase_next; // Next phase selection
  logic [3:0] quant_reg; // Measured quantity shown in display mode
  logic [3:0] quant_next; // Next quantity selection
  logic [9:0] addr_reg; // Selected parameter address
  logic [9:0] addr_next; // Next parameter address
  logic [1:0] digit_reg; // Digit being edited, zero is the lowest
  logic [1:0] digit_next; // Next edited digit
  logic [15:0] entry_reg; // Password typed so far, BCD
  logic [15:0] entry_next; // Next typed password
  logic [15:0] pw_reg; // Stored display password, zero means none
  logic [15:0] pw_next; // Next stored password
  logic [63:0] idle_reg; // Quiet cycles outside display mode, wide enough for the full timeout
  logic [63:0] idle_next; // Next idle count
  logic [31:0] blink_cnt_reg; // Cycles into the current blink half
  logic [31:0] blink_cnt_next; // Next blink count
  logic blink_reg; // Blink phase, high blanks the flashing digits
  logic blink_next; // Next blink phase
  logic [15:0] shown_reg; // Value on the display, held in a register
  logic [15:0] shown_next; // Next displayed value
  logic we_next; // Write strobe for the next cycle
  logic [15:0] wdata_next; // Write data for the next cycle
  logic up; // Short press on either key
  logic down; // Long press on either key

  // One decimal digit of a BCD word stepped up or down with wrap
  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] d, input logic inc);
    logic [3:0] n;
    logic [15:0] r;
    n = v[d*4 +: 4];
    r = v;
    if (inc) begin
      n = (n >= 4'h9) ? 4'h0 : n + 4'h1;
    end else begin
      n = (n == 4'h0) ? 4'h9 : n - 4'h1;
    end
    r[d*4 +: 4] = n;
    return r;
  endfunction

  always_comb begin
    mode_next = mode_reg;
    phase_next = phase_reg;
    quant_next = quant_reg;
    addr_next = addr_reg;
    digit_next = digit_reg;
    entry_next = entry_reg;
    pw_next = pw_reg;
    we_next = 1'b0;
    wdata_next = entry_reg;
    up = ev1.short_press | ev2.short_press;
    down = ev1.long_press | ev2.long_press;
    // Idle timer runs only outside display mode and stops at its limit
    idle_next = idle_reg;
    if (any_key || mode_reg == MODE_DISPLAY) begin
      idle_next = 64'h0;
    end else if (idle_reg < IDLE_CYC) begin
      idle_next = idle_reg + 64'h1;
    end
    // Free-running blink phase for the flashing digits
    blink_cnt_next = (blink_cnt_reg >= 32'(BLINK_CYC - 1)) ? 32'h0 : blink_cnt_reg + 32'h1;
    blink_next = (blink_cnt_reg >= 32'(BLINK_CYC - 1)) ? !blink_reg : blink_reg;
    case (mode_reg)
      MODE_DISPLAY: begin
        if (toggle) begin
          digit_next = 2'h0;
          entry_next = 16'h0000;
          // Ask for the password only when one is stored; see RULE7 RULE11
          mode_next = (pw_reg != 16'h0000) ? MODE_PASSWORD : MODE_PROGRAM;
          addr_next = ADDR_RESET;
        end else begin
          // Key one pages phases, key two pages quantities; see RULE5 RULE6
          if (ev1.short_press) begin
            phase_next = (32'(phase_reg) >= NUM_PHASES - 1) ? 2'h0 : phase_reg + 2'h1; // see RULE1
          end else if (ev1.long_press) begin
            phase_next = (phase_reg == 2'h0) ? 2'(NUM_PHASES - 1) : phase_reg - 2'h1; // see RULE2
          end
          if (ev2.short_press) begin
            quant_next = (32'(quant_reg) >= NUM_QUANTITIES - 1) ? 4'h0 : quant_reg + 4'h1;
          end else if (ev2.long_press) begin
            quant_next = (quant_reg == 4'h0) ? 4'(NUM_QUANTITIES - 1) : quant_reg - 4'h1;
          end
        end
      end
      MODE_PASSWORD: begin
        // Key one steps the digit, key two moves to the next digit
        if (toggle || idle_reg >= IDLE_CYC) begin
          mode_next = MODE_DISPLAY; // see RULE9
        end else if (ev1.short_press || ev1.long_press) begin
          entry_next = bcd_step(entry_reg, digit_reg, ev1.short_press); // see RULE10
        end else if (ev2.short_press) begin
          if (digit_reg == 2'h3) begin
            mode_next = (entry_reg == pw_reg) ? MODE_PROGRAM : MODE_DISPLAY;
            digit_next = 2'h0;
          end else begin
            digit_next = digit_reg + 2'h1;
          end
        end
      end
      MODE_PROGRAM: begin
        if (toggle || idle_reg >= IDLE_CYC) begin
          mode_next = MODE_DISPLAY; // see RULE3 RULE9
        end else begin
          // Key one steps the address, key two edits a digit of the value and stores it
          if (ev1.short_press) begin
            addr_next = (addr_reg == ADDR_LAST) ? ADDR_RESET : addr_reg + 10'h1; // see RULE1
          end else if (ev1.long_press) begin
            addr_next = (addr_reg == ADDR_RESET) ? ADDR_LAST : addr_reg - 10'h1; // see RULE2
          end
          if (up || down) begin
            entry_next = i_param_value;
          end
          if (ev2.short_press || ev2.long_press) begin
            wdata_next = bcd_step(i_param_value, digit_reg, ev2.short_press);
            we_next = 1'b1;
            if (addr_reg == PASSWORD_ADDR) begin
              pw_next = wdata_next; // see RULE11
            end
          end
        end
      end
      default: begin
        // Unused encoding falls back to display mode
        mode_next = MODE_DISPLAY;
      end
    endcase
    // Shown value follows the mode being entered: typed password or stored content
    shown_next = (mode_next == MODE_PASSWORD) ? entry_next : i_param_value;
  end

  logic we_reg; // One-cycle write strobe
  logic [15:0] wdata_reg; // Data of the pending write
  // Register mode, selectors, timers and the write port
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_DISPLAY; // see RULE4
      phase_reg <= PHASE_RESET;
      quant_reg <= QUANTITY_RESET;
      addr_reg <= ADDR_RESET;
      digit_reg <= 2'h0;
      entry_reg <= 16'h0000;
      pw_reg <= PASSWORD_RESET; // see RULE12
      idle_reg <= 64'h0;
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
      we_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      shown_reg <= 16'h0000;
    end else begin
      mode_reg <= mode_next;
      phase_reg <= phase_next;
      quant_reg <= quant_next;
      addr_reg <= addr_next;
      digit_reg <= digit_next;
      entry_reg <= entry_next;
      pw_reg <= pw_next;
      idle_reg <= idle_next;
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
      we_reg <= we_next;
      wdata_reg <= wdata_next;
      shown_reg <= shown_next;
    end
  end

  // Display bundle from registers; indicator steady and address blinking in programming
  always_comb begin
    o_display = '0;
    o_display.programming_indicator_text = (mode_reg == MODE_PROGRAM); // see RULE8
    o_display.addr_blank = (mode_reg == MODE_PROGRAM) && blink_reg; // see RULE8
    o_display.password_query = (mode_reg == MODE_PASSWORD);
    o_display.digit_blank = (mode_reg == MODE_PASSWORD) && blink_reg;
    o_display.phase = phase_reg;
    o_display.quantity = quant_reg;
    o_display.addr = addr_reg;
    o_display.digit_sel = digit_reg;
    o_display.value = shown_reg; // see RULE10
  end
  // Parameter store port straight from registers
  assign o_param_addr = addr_reg;
  assign o_param_wdata = wdata_reg;
  assign o_param_we = we_reg;
endmodule

/* File: sim/panel_checker.sv */
// Port checker for the two-key panel
`timescale 1ns/1ps
module panel_checker #(
  parameter longint unsigned BOTH_CYC = 50,
  parameter longint unsigned IDLE_CYC = 500
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_key1,
  input wire logic i_key2,
  input wire panel_pkg::display_t o_display,
  input wire logic [9:0] o_param_addr,
  input wire logic [15:0] o_param_wdata,
  input wire logic o_param_we
);
  import panel_pkg::*;
  logic [31:0] both_reg, both_next; // Cycles both keys held
  logic [31:0] quiet_reg, quiet_next; // Cycles with no key
  logic start_reg, start_next; // Mode seen as chord began
  logic in_mode; // Programming or password entry active
  assign in_mode = o_display.programming_indicator_text | o_display.password_query;
  // Next values of the counters
  always_comb begin
    both_next = (i_key1 && i_key2) ? both_reg + 1 : 32'h0;
    quiet_next = (i_key1 || i_key2) ? 32'h0 : quiet_reg + 1;
    start_next = (both_reg == 32'h0) ? in_mode : start_reg;
  end
  // Counter registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      both_reg <= 32'h0;
      quiet_reg <= 32'h0;
      start_reg <= 1'b0;
    end else begin
      both_reg <= both_next;
      quiet_reg <= quiet_next;
      start_reg <= start_next;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Chord just short of its hold time, and well past it
  sequence s_chord_early;
    both_reg == BOTH_CYC - 1;
  endsequence
  sequence s_chord_late;
    both_reg == BOTH_CYC + 8;
  endsequence
  a_chord_too_early: assert property (s_chord_early |-> in_mode == start_reg)
    else $error("mode changed before chord time");
  a_chord_toggles_mode: assert property (s_chord_late |-> in_mode != start_reg)
    else $error("chord did not toggle mode");
  a_we_one_cycle: assert property (o_param_we |=> !o_param_we)
    else $error("write pulse too long");
  a_we_in_program: assert property (o_param_we |-> o_display.programming_indicator_text && o_param_addr == o_display.addr)
    else $error("write outside programming or address mismatch");
  a_modes_exclusive: assert property (!(o_display.programming_indicator_text && o_display.password_query))
    else $error("both modes shown");
  a_idle_exit: assert property (quiet_reg == IDLE_CYC + 12 |-> !in_mode)
    else $error("no return to display after idle");
  a_quiet_stable: assert property (quiet_reg > 8 |-> $stable(o_display.phase) && $stable(o_display.quantity) && !o_param_we)
    else $error("action without key press");
  a_quantity_range: assert property (o_display.quantity < 4'hc)
    else $error("quantity out of range");
  a_program_digit: assert property (o_display.programming_indicator_text |-> o_display.digit_sel == 2'h0)
    else $error("program digit not zero");
  a_blank_in_program: assert property (o_display.addr_blank |-> o_display.programming_indicator_text)
    else $error("address blinking outside programming");
  a_blank_in_query: assert property (o_display.digit_blank |-> o_display.password_query)
    else $error("digit blinking outside password entry");
endmodule
bind two_key_panel_mode_control panel_checker #(.BOTH_CYC(BOTH_CYC), .IDLE_CYC(IDLE_CYC)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_key1(i_key1), .i_key2(i_key2), .o_display(o_display),
  .o_param_addr(o_param_addr), .o_param_wdata(o_param_wdata), .o_param_we(o_param_we));

/* File: sim/panel_operator.sv */
// Operator model pressing the two panel keys
`timescale 1ns/1ps
module panel_operator (
  input wire logic i_clk,
  output logic o_key1,
  output logic o_key2
);
  // Keys start released
  initial begin
    o_key1 = 1'b0;
    o_key2 = 1'b0;
  end
  // Press the chosen keys for hold cycles, then rest ten cycles
  task automatic press(input logic [1:0] keys, input int hold);
    @(negedge i_clk);
    o_key1 = keys[0];
    o_key2 = keys[1];
    repeat (hold) @(negedge i_clk);
    o_key1 = 1'b0;
    o_key2 = 1'b0;
    repeat (10) @(negedge i_clk);
  endtask
endmodule

/* File: sim/two_key_panel_mode_control_tb.sv */
// Self-checking bench of the two-key panel
`timescale 1ns/1ps
module two_key_panel_mode_control_tb;
  import panel_pkg::*;
  localparam int BC = 50; // Shortened chord time
  localparam int IC = 500; // Shortened idle time
  localparam int BK = 8; // Shortened blink half period
  logic i_clk, i_rst_n, i_key1, i_key2, o_param_we, we_seen;
  logic [15:0] i_param_value, o_param_wdata, wdata_seen;
  logic [9:0] o_param_addr, addr_seen;
  display_t o_display;
  logic [31:0] lfsr, cyc;
  logic [1:0] ph;
  logic [3:0] qu;
  int fail_count, checks_done, blink_ones;
  panel_operator op (.i_clk(i_clk), .o_key1(i_key1), .o_key2(i_key2));
  two_key_panel_mode_control #(.LONG_CYC(20), .BOTH_CYC(BC), .IDLE_CYC(IC), .BLINK_CYC(BK)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_key1(i_key1), .i_key2(i_key2), .i_param_value(i_param_value),
    .o_display(o_display), .o_param_addr(o_param_addr), .o_param_wdata(o_param_wdata), .o_param_we(o_param_we));
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Wrapping step up or down modulo n
  function automatic logic [3:0] step(input logic [3:0] v, input logic up, input int n);
    return 4'((up ? v + 1 : v + n - 1) % n);
  endfunction
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // Cycle ceiling and capture of writes
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_param_we === 1'b1) begin
      we_seen <= 1'b1;
      addr_seen <= o_param_addr;
      wdata_seen <= o_param_wdata;
    end
    if (cyc == 30000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    i_rst_n = 1'b0;
    i_param_value = 16'h0000;
    lfsr = 32'h59bb0349;
    cyc = 0;
    we_seen = 1'b0;
    repeat (4) @(negedge i_clk);
    i_rst_n = 1'b1;
    repeat (6) @(negedge i_clk);
    chk("reset", 16'h0000, {o_display.phase, o_display.quantity, o_param_we, o_display.programming_indicator_text,
      o_display.password_query, 7'h0});
    ph = 2'h0;
    qu = 4'h0;
    // Random short and long presses in display mode
    for (int i = 0; i < 16; i++) begin
      lfsr = nxt(lfsr);
      i_param_value = lfsr[31:16];
      op.press({lfsr[0], ~lfsr[0]}, lfsr[1] ? 24 + lfsr[4:2] : 6 + lfsr[4:2]);
      if (lfsr[0]) qu = step(qu, ~lfsr[1], 12);
      else ph = 2'(step({2'h0, ph}, ~lfsr[1], 4));
      chk("phase", {14'h0, ph}, {14'h0, o_display.phase});
      chk("quantity", {12'h0, qu}, {12'h0, o_display.quantity});
    end
    op.press(2'b11, BC + 10);
    chk("program", 16'h1, {15'h0, o_display.programming_indicator_text});
    // Address digits flash: blank for half of two whole blink periods
    blink_ones = 0;
    repeat (4 * BK) begin
      @(negedge i_clk);
      blink_ones += int'(o_display.addr_blank);
    end
    chk("blink", 16'(2 * BK), 16'(blink_ones));
    op.press(2'b01, 26);
    chk("addr", {6'h0, ADDR_LAST}, {6'h0, o_param_addr});
    for (int i = 0; i < 501; i++) op.press(2'b01, 6);
    chk("addr", {6'h0, PASSWORD_ADDR}, {6'h0, o_param_addr});
    i_param_value = 16'h1234;
    op.press(2'b10, 8);
    chk("write", 16'h1, {15'h0, we_seen});
    chk("waddr", {6'h0, PASSWORD_ADDR}, {6'h0, addr_seen});
    chk("wdata", 16'h1235, wdata_seen);
    chk("value", 16'h1234, o_display.value);
    i_param_value = 16'h1235;
    repeat (IC + 20) @(negedge i_clk);
    chk("idle", 16'h0, {15'h0, o_display.programming_indicator_text});
    op.press(2'b11, BC + 10);
    chk("query", 16'h1, {15'h0, o_display.password_query});
    // Enter the stored password, low digit first
    for (int d = 0; d < 4; d++) begin
      repeat (4'(16'h1235 >> (4 * d))) op.press(2'b01, 6);
      chk("entry", {12'h0, 4'(16'h1235 >> (4 * d))}, {12'h0, o_display.value[4 * d +: 4]});
      op.press(2'b10, 6);
    end
    chk("unlock", 16'h1, {15'h0, o_display.programming_indicator_text});
    op.press(2'b11, BC + 10);
    chk("leave", 16'h0, {15'h0, o_display.programming_indicator_text});
    // A wrong password sends the panel back to display mode
    op.press(2'b11, BC + 10);
    chk("query", 16'h1, {15'h0, o_display.password_query});
    repeat (4) op.press(2'b10, 6);
    chk("refuse", 16'h0, {14'h0, o_display.password_query, o_display.programming_indicator_text});
    results();
  end
endmodule
